/* hw/mau_moving_average_unit.sv */
// Moving average unit: per-scan sample store, sliding mean, register port
//
// Operation
// - Error indicator on zero count, else off
// - First count-minus-one samples fill work area
// - Each store increments pointer in bits 07:00
// - Before full count, result copies source, flag off
// - At full count, mean written, flag bit 15 set
// - Later cycles average latest count-many samples
// - Counts above 64 act as 64
// - Pointer wraps to zero, storage circular
// - Mean rounded to nearest integer
// - Condition rising edge clears processing word
`timescale 1ns/1ns
`include "mau_regs.svh"

module mau_moving_average_unit
    import mau_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Scan engine operands
    input wire logic scan_strobe,
    input wire logic exec_cond,
    input wire logic [15:0] source_word,
    input wire logic [15:0] sample_count,
    // Scan engine answers
    output logic busy,
    output logic error_indicator,
    output mau_word_t result_word,
    output mau_word_t proc_info,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output mau_word_t reg_rdata,
    // Interrupt
    output logic irq
);

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    function automatic logic [6:0] eff_count(input logic [15:0] n);
        if (n > {9'h000, `MAU_MAX_COUNT}) begin
            eff_count = `MAU_MAX_COUNT;
        end else begin
            eff_count = n[6:0];
        end
    endfunction

    function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] b);
        addr_hit = (a == b);
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    mau_word_t work_mem [0:63];
    mau_state_t state_q;
    mau_state_t state_d;
    mau_word_t result_q;
    mau_word_t info_q;
    mau_word_t rdata_q;
    logic err_q;
    logic prev_exec_q;
    logic [21:0] sum_q;
    logic [5:0] idx_q;
    logic [6:0] n_q;
    logic [`MAU_STS_WIDTH-1:0] sts_q;
    logic [`MAU_STS_WIDTH-1:0] mask_q;
    logic ctrl_en_q;

    // ------------------------------------------------------------
    // Scan acceptance
    // ------------------------------------------------------------
    wire idle = (state_q == MAU_ST_IDLE);
    wire scan_go = scan_strobe && ctrl_en_q && idle;
    wire exec_now = scan_go && exec_cond;
    wire exec_rise = exec_now && !prev_exec_q;
    wire count_zero = (sample_count == 16'h0000);
    wire store = exec_now && !count_zero;
    wire [6:0] n_eff = eff_count(sample_count);

    // ------------------------------------------------------------
    // Pointer and flag arithmetic
    // ------------------------------------------------------------
    wire [15:0] info_base = exec_rise ? `MAU_INFO_RST : info_q;
    wire [7:0] ptr_cur = info_base[`MAU_PTR_MSB:`MAU_PTR_LSB];
    wire valid_cur = info_base[`MAU_VALID_BIT];
    wire ptr_out = (ptr_cur >= {1'b0, n_eff});
    wire [5:0] wr_idx = ptr_out ? 6'h00 : ptr_cur[5:0];
    wire last_slot = ({1'b0, wr_idx} == (n_eff - 7'h01));
    wire [7:0] ptr_inc = {2'b00, wr_idx} + 8'h01;
    wire [7:0] ptr_nxt = last_slot ? 8'h00 : ptr_inc;
    wire valid_nxt = valid_cur || last_slot;
    wire [15:0] info_nxt = {valid_nxt, 7'h00, ptr_nxt};
    wire avg_rise = store && valid_nxt && !valid_cur;

    // ------------------------------------------------------------
    // Summation over the work area
    // ------------------------------------------------------------
    wire [21:0] sum_add = sum_q + {6'h00, work_mem[idx_q]};
    wire sum_last = (state_q == MAU_ST_SUM) && ({1'b0, idx_q} == (n_q - 7'h01));
    wire [21:0] dividend = sum_add + {16'h0000, n_q[6:1]};
    wire div_start = sum_last;
    mau_word_t div_quot;
    logic div_done;

    mau_round_div u_div (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .start(div_start),
        .dividend(dividend),
        .divisor(n_q),
        .quotient(div_quot),
        .done(div_done)
    );

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            MAU_ST_IDLE: begin
                if (store && valid_nxt) begin
                    state_d = MAU_ST_SUM;
                end
            end
            MAU_ST_SUM: begin
                if (sum_last) begin
                    state_d = MAU_ST_DIV;
                end
            end
            MAU_ST_DIV: begin
                if (div_done) begin
                    state_d = MAU_ST_IDLE;
                end
            end
            default: begin
                state_d = MAU_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_q <= MAU_ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // Sample store
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (store) begin
            work_mem[wr_idx] <= source_word;
        end
    end

    // ------------------------------------------------------------
    // Summation registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sum_q <= 22'h00_0000;
            idx_q <= 6'h00;
            n_q <= 7'h01;
        end else if (store && valid_nxt) begin
            sum_q <= 22'h00_0000;
            idx_q <= 6'h00;
            n_q <= n_eff;
        end else if (state_q == MAU_ST_SUM) begin
            sum_q <= sum_add;
            idx_q <= idx_q + 6'h01;
        end
    end

    // ------------------------------------------------------------
    // Execution edge tracking
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            prev_exec_q <= 1'b1;
        end else if (scan_go) begin
            prev_exec_q <= exec_cond;
        end
    end

    // ------------------------------------------------------------
    // Error indicator
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            err_q <= 1'b0;
        end else if (exec_now) begin
            err_q <= count_zero;
        end
    end

    // ------------------------------------------------------------
    // Result word
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            result_q <= `MAU_RESULT_RST;
        end else if (store && !valid_nxt) begin
            result_q <= source_word;
        end else if ((state_q == MAU_ST_DIV) && div_done) begin
            result_q <= div_quot;
        end
    end

    // ------------------------------------------------------------
    // Processing-information word
    // ------------------------------------------------------------
    wire sw_info_wr = reg_wr && addr_hit(reg_addr, `MAU_ADDR_INFO);

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            info_q <= `MAU_INFO_RST;
        end else if (store) begin
            info_q <= info_nxt;
        end else if (exec_rise) begin
            info_q <= `MAU_INFO_RST;
        end else if (sw_info_wr) begin
            info_q <= reg_wdata;
        end
    end

    // ------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------
    wire sw_sts_wr = reg_wr && addr_hit(reg_addr, `MAU_ADDR_STATUS);
    wire sw_mask_wr = reg_wr && addr_hit(reg_addr, `MAU_ADDR_MASK);
    wire sw_ctrl_wr = reg_wr && addr_hit(reg_addr, `MAU_ADDR_CTRL);
    wire result_evt = (store && !valid_nxt) || ((state_q == MAU_ST_DIV) && div_done);
    wire [`MAU_STS_WIDTH-1:0] sts_set = {result_evt, avg_rise, exec_now && count_zero};
    wire [`MAU_STS_WIDTH-1:0] sts_clr = sw_sts_wr ? reg_wdata[`MAU_STS_WIDTH-1:0] : 3'h0;
    wire [`MAU_STS_WIDTH-1:0] sts_d = (sts_q & ~sts_clr) | sts_set;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sts_q <= `MAU_STS_RST;
            mask_q <= `MAU_MASK_RST;
            ctrl_en_q <= `MAU_CTRL_RST;
        end else begin
            sts_q <= sts_d;
            if (sw_mask_wr) begin
                mask_q <= reg_wdata[`MAU_STS_WIDTH-1:0];
            end
            if (sw_ctrl_wr) begin
                ctrl_en_q <= reg_wdata[`MAU_CTRL_EN];
            end
        end
    end

    // ------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------
    wire [7:0] work_base = `MAU_ADDR_WORK_BASE;
    wire work_sel = (reg_addr[7:6] == work_base[7:6]);
    wire [15:0] flags_word = {13'h0000, busy, prev_exec_q, err_q};
    wire [15:0] rd_mux =
        work_sel ? work_mem[reg_addr[5:0]] :
        addr_hit(reg_addr, `MAU_ADDR_RESULT) ? result_q :
        addr_hit(reg_addr, `MAU_ADDR_INFO) ? info_q :
        addr_hit(reg_addr, `MAU_ADDR_STATUS) ? {13'h0000, sts_q} :
        addr_hit(reg_addr, `MAU_ADDR_MASK) ? {13'h0000, mask_q} :
        addr_hit(reg_addr, `MAU_ADDR_CTRL) ? {15'h0000, ctrl_en_q} :
        addr_hit(reg_addr, `MAU_ADDR_FLAGS) ? flags_word :
        16'h0000;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rdata_q <= 16'h0000;
        end else if (reg_rd) begin
            rdata_q <= rd_mux;
        end else begin
            rdata_q <= 16'h0000;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign busy = !idle;
    assign error_indicator = err_q;
    assign result_word = result_q;
    assign proc_info = info_q;
    assign reg_rdata = rdata_q;
    assign irq = |(sts_q & mask_q);

endmodule

/* hw/mau_regs.svh */
// Register offsets, field positions, reset values and counts of the moving average unit
`ifndef MAU_REGS_SVH
`define MAU_REGS_SVH

// ------------------------------------------------------------
// Register word addresses
// ------------------------------------------------------------
`define MAU_ADDR_RESULT 8'h00
`define MAU_ADDR_INFO 8'h01
`define MAU_ADDR_STATUS 8'h02
`define MAU_ADDR_MASK 8'h03
`define MAU_ADDR_CTRL 8'h04
`define MAU_ADDR_FLAGS 8'h05
`define MAU_ADDR_WORK_BASE 8'h40

// ------------------------------------------------------------
// Processing-information word fields
// ------------------------------------------------------------
`define MAU_PTR_LSB 0
`define MAU_PTR_MSB 7
`define MAU_VALID_BIT 15
`define MAU_INFO_RST 16'h0000

// ------------------------------------------------------------
// Status and mask bit positions
// ------------------------------------------------------------
`define MAU_STS_ERROR 0
`define MAU_STS_AVG_VALID 1
`define MAU_STS_RESULT 2
`define MAU_STS_WIDTH 3
`define MAU_STS_RST 3'h0
`define MAU_MASK_RST 3'h0

// ------------------------------------------------------------
// Control word
// ------------------------------------------------------------
`define MAU_CTRL_EN 0
`define MAU_CTRL_RST 1'h1

// ------------------------------------------------------------
// Counts and result reset value
// ------------------------------------------------------------
`define MAU_MAX_COUNT 7'h40
`define MAU_DIV_STEPS 5'h16
`define MAU_RESULT_RST 16'h0000

`endif

/* hw/mau_pkg.sv */
// Types shared by the moving average unit
package mau_pkg;

    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MAU_ST_IDLE = 2'b00,
        MAU_ST_SUM = 2'b01,
        MAU_ST_DIV = 2'b10
    } mau_state_t;

    typedef logic [15:0] mau_word_t;

endpackage

/* hw/mau_round_div.sv */
// Sequential restoring divider for the rounded mean
`timescale 1ns/1ns
`include "mau_regs.svh"

module mau_round_div
    import mau_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Request
    input wire logic start,
    input wire logic [21:0] dividend,
    input wire logic [6:0] divisor,
    // Answer
    output mau_word_t quotient,
    output logic done
);

    // ------------------------------------------------------------
    // Datapath
    // ------------------------------------------------------------
    logic [21:0] quo_q;
    logic [7:0] rem_q;
    logic [6:0] dvs_q;
    logic [4:0] cnt_q;
    logic run_q;
    logic done_q;

    wire [7:0] trial = {rem_q[6:0], quo_q[21]};
    wire fits = trial >= {1'b0, dvs_q};
    wire [7:0] rem_nx = fits ? trial - {1'b0, dvs_q} : trial;
    wire last_step = run_q && (cnt_q == `MAU_DIV_STEPS - 5'h01);

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            quo_q <= 22'h00_0000;
            rem_q <= 8'h00;
            dvs_q <= 7'h01;
            cnt_q <= 5'h00;
            run_q <= 1'b0;
            done_q <= 1'b0;
        end else if (start) begin
            quo_q <= dividend;
            rem_q <= 8'h00;
            dvs_q <= divisor;
            cnt_q <= 5'h00;
            run_q <= 1'b1;
            done_q <= 1'b0;
        end else begin
            done_q <= last_step;
            if (run_q) begin
                quo_q <= {quo_q[20:0], fits};
                rem_q <= rem_nx;
                cnt_q <= cnt_q + 5'h01;
                run_q <= !last_step;
            end
        end
    end

    assign quotient = quo_q[15:0];
    assign done = done_q;

endmodule

/* verif/mau_scan_model.sv */
// Scan engine model issuing one scan strobe per call
`timescale 1ns/1ns

module mau_scan_model (
    // Clock and answer
    input wire logic sys_clk,
    input wire logic busy,
    // Operands
    output logic scan_strobe,
    output logic exec_cond,
    output logic [15:0] source_word,
    output logic [15:0] sample_count
);
    initial begin
        scan_strobe = 1'b0;
        exec_cond = 1'b0;
        source_word = 16'h0000;
        sample_count = 16'h0000;
    end
    // One strobe, operands scrambled after it, then wait out busy
    task automatic issue(input logic c, input logic [15:0] s, input logic [15:0] n);
        int w;
        w = 0;
        @(posedge sys_clk);
        scan_strobe <= 1'b1;
        exec_cond <= c;
        source_word <= s;
        sample_count <= n;
        @(posedge sys_clk);
        scan_strobe <= 1'b0;
        source_word <= ~s;
        sample_count <= ~n;
        @(posedge sys_clk);
        while (busy && w < 200) begin
            w++;
            @(posedge sys_clk);
        end
        #1;
    endtask
endmodule

/* verif/mau_avg_chk.sv */
// Assertions on the scan side of the moving average unit
`timescale 1ns/1ns
`include "mau_regs.svh"

module mau_avg_chk
    import mau_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Scan side
    input wire logic scan_strobe,
    input wire logic exec_cond,
    input wire logic [15:0] source_word,
    input wire logic [15:0] sample_count,
    input wire logic busy,
    input wire logic error_indicator,
    input wire mau_word_t result_word,
    input wire mau_word_t proc_info,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr
);
    logic en_q;
    logic prev_q;
    wire logic acc = scan_strobe && !busy && en_q;
    wire logic act = acc && exec_cond && sample_count != 16'h0000;
    wire logic [15:0] eff_n = (sample_count > 16'h0040) ? 16'h0040 : sample_count;
    wire logic [15:0] ptr_n = {8'h00, proc_info[7:0]} + 16'h0001;
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            en_q <= 1'b1;
            prev_q <= 1'b1;
        end else begin
            if (reg_wr && reg_addr == `MAU_ADDR_CTRL) en_q <= reg_wdata[0];
            if (acc) prev_q <= exec_cond;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_error_zero: assert property (acc && exec_cond && sample_count == 16'h0000 |=> error_indicator)
        else $error("error flag missing on zero count");
    a_error_clear: assert property (act |=> !error_indicator)
        else $error("error flag stuck");
    a_idle_hold: assert property (!busy && !reg_wr && !(acc && exec_cond)
        |=> $stable(result_word) && $stable(proc_info))
        else $error("words changed without active scan");
    a_clear_rise: assert property (act && !prev_q && eff_n > 16'h0001 |=> proc_info == 16'h0001)
        else $error("rising condition did not clear");
    a_ptr_step: assert property (act && prev_q && !proc_info[15] && ptr_n < eff_n
        |=> proc_info == $past(ptr_n) && result_word == $past(source_word))
        else $error("fill step wrong");
    a_valid_set: assert property (act && prev_q && !proc_info[15] && ptr_n == eff_n
        |=> proc_info == 16'h8000 && busy)
        else $error("full count not flagged");
    a_slide_ptr: assert property (act && prev_q && proc_info[15] && ptr_n <= eff_n
        |=> proc_info == (($past(ptr_n) == $past(eff_n)) ? 16'h8000 : (16'h8000 | $past(ptr_n))))
        else $error("sliding pointer wrong");
    a_busy_bound: assert property ($rose(busy) |-> ##[1:100] !busy)
        else $error("mean never finished");
    c_rise: cover property (act && !prev_q);
    c_slide: cover property (act && proc_info[15]);
    c_zero: cover property (acc && exec_cond && sample_count == 16'h0000);
endmodule

/* verif/mau_moving_average_unit_bench.sv */
// Self-checking bench of the moving average unit
`timescale 1ns/1ns
`include "mau_regs.svh"

module mau_moving_average_unit_bench import mau_pkg::*;;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic busy, error_indicator, irq, scan_strobe, exec_cond;
    logic [15:0] source_word, sample_count, n;
    logic [15:0] reg_wdata = 16'h0000;
    mau_word_t result_word, proc_info, reg_rdata;
    logic [7:0] reg_addr = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    int errors = 0;
    int num_checks = 0;
    logic [15:0] slots [64];
    logic [15:0] fixed [4] = '{16'h0001, 16'h0040, 16'h0064, 16'hffff};
    int ptr = 0;
    logic valid = 1'b0;
    logic prev = 1'b1;
    logic err = 1'b0;
    logic en_sw = 1'b1;
    logic [15:0] exp_res = 16'h0000;
    always #4 sys_clk = ~sys_clk;
    mau_scan_model scan (.sys_clk(sys_clk), .busy(busy), .scan_strobe(scan_strobe),
        .exec_cond(exec_cond), .source_word(source_word), .sample_count(sample_count));
    mau_moving_average_unit DUT (.sys_clk(sys_clk), .rst_n(rst_n), .scan_strobe(scan_strobe),
        .exec_cond(exec_cond), .source_word(source_word), .sample_count(sample_count),
        .busy(busy), .error_indicator(error_indicator), .result_word(result_word),
        .proc_info(proc_info), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
    // ------------------------------------------------------------
    // Compare, bus and scan tasks
    // ------------------------------------------------------------
    task automatic chk16(input mau_word_t got, input mau_word_t exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk16({15'h0000, got}, {15'h0000, exp});
    endtask
    task automatic reg_wr_t(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic reg_rd_t(input logic [7:0] a, input mau_word_t e);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk16(reg_rdata, e);
    endtask
    task automatic scan_t(input logic c, input logic [15:0] s, input logic [15:0] cnt);
        int k;
        int idx;
        int sum;
        k = (cnt > 64) ? 64 : cnt;
        scan.issue(c, s, cnt);
        if (en_sw && c && k == 0) err = 1'b1;
        else if (en_sw && c) begin
            err = 1'b0;
            if (!prev) ptr = 0;
            if (!prev) valid = 1'b0;
            idx = (ptr >= k) ? 0 : ptr;
            slots[idx] = s;
            ptr = (idx + 1 == k) ? 0 : idx + 1;
            if (!valid && ptr != 0) exp_res = s;
            else begin
                valid = 1'b1;
                sum = k / 2;
                for (int i = 0; i < k; i++) sum += slots[i];
                exp_res = 16'(sum / k);
            end
        end
        if (en_sw) prev = c;
        chk16(result_word, exp_res);
        chk16(proc_info, {valid, 7'h00, 8'(ptr)});
        chk1(error_indicator, err);
    endtask
    task automatic end_sim();
        $display("checks=%0d errors=%0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        void'($urandom(11));
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        reg_rd_t(`MAU_ADDR_CTRL, 16'h0001);
        reg_rd_t(`MAU_ADDR_STATUS, 16'h0000);
        reg_rd_t(`MAU_ADDR_MASK, 16'h0000);
        reg_wr_t(8'h10, 16'hffff);
        reg_rd_t(8'h10, 16'h0000);
        reg_wr_t(`MAU_ADDR_MASK, 16'h0002);
        $display("register test done");
        for (int i = 0; i < 4; i++) scan_t(1'b1, i[15:0], 16'h0003);
        chk1(irq, 1'b1);
        reg_rd_t(`MAU_ADDR_WORK_BASE, 16'h0003);
        reg_wr_t(`MAU_ADDR_STATUS, 16'h0007);
        chk1(irq, 1'b0);
        scan_t(1'b1, 16'h1234, 16'h0000);
        reg_rd_t(`MAU_ADDR_STATUS, 16'h0001);
        chk1(irq, 1'b0);
        reg_wr_t(`MAU_ADDR_CTRL, 16'h0000);
        en_sw = 1'b0;
        scan_t(1'b1, 16'h0055, 16'h0005);
        reg_wr_t(`MAU_ADDR_CTRL, 16'h0001);
        en_sw = 1'b1;
        $display("walk test done");
        for (int j = 0; j < 7; j++) begin
            n = (j < 4) ? fixed[j] : 16'(1 + $urandom % 64);
            scan_t(1'b0, 16'h0000, n);
            for (int i = 0; i < ((n > 64) ? 64 : n) + 3; i++) begin
                scan_t(1'b1, 16'($urandom), n);
            end
            $display("group %0d done", j);
        end
        end_sim();
    end
    initial begin
        #480000;
        errors++;
        end_sim();
    end
endmodule

bind mau_moving_average_unit mau_avg_chk chk (.sys_clk(sys_clk), .rst_n(rst_n),
    .scan_strobe(scan_strobe), .exec_cond(exec_cond), .source_word(source_word),
    .sample_count(sample_count), .busy(busy), .error_indicator(error_indicator),
    .result_word(result_word), .proc_info(proc_info), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr));
